/* File: core/cansf_pkg.sv */
// Shared constants and state types for the abort, select and filter control.
package cansf_pkg;

    // Register byte offsets on the Avalon-MM slave.
    localparam logic [4:0] OFS_ABORT_ACK = 5'h00;
    localparam logic [4:0] OFS_TX_SELECT = 5'h04;
    localparam logic [4:0] OFS_FILTER_CTL = 5'h08;
    localparam logic [4:0] OFS_EMPTY_FLAGS = 5'h0c;
    localparam logic [4:0] OFS_ABORT_REQ = 5'h10;
    localparam logic [4:0] OFS_INIT_CTL = 5'h14;
    localparam logic [4:0] OFS_TX_WINDOW = 5'h18;

    // Widths and counts.
    localparam int NUM_TXBUF = 3;
    localparam int DATA_W = 32;

    // Field positions.
    localparam int MODE_LSB = 4;
    localparam int MODE_MSB = 5;
    localparam int HIT_LSB = 0;
    localparam int HIT_MSB = 2;
    localparam int INIT_REQ_BIT = 0;
    localparam int INIT_ACK_BIT = 1;

    // Reset values.
    localparam logic [2:0] EMPTY_RST = 3'h7;
    localparam logic [2:0] FLAGS_RST = 3'h0;
    localparam logic [1:0] MODE_RST = 2'h0;
    localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;

    // Filter organisation.
    typedef enum logic [1:0] {
        FM_TWO_32 = 2'b00,
        FM_FOUR_16 = 2'b01,
        FM_EIGHT_8 = 2'b10,
        FM_CLOSED = 2'b11
    } cansf_mode_t;

    // Avalon-MM response codes.
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    localparam logic [1:0] RESP_DECERR = 2'b11;

    // Whole state of the control block.
    typedef struct packed {
        logic wait_req;
        logic [DATA_W-1:0] rdata;
        logic [1:0] resp;
        logic init_req;
        logic init_ack;
        logic init_mode;
        logic [2:0] empty;
        logic [2:0] queued;
        logic [2:0] abort_done;
        logic [2:0] abort_req;
        logic [2:0] select;
        cansf_mode_t mode;
        logic closed;
        logic [2:0] hit;
        logic [NUM_TXBUF-1:0][DATA_W-1:0] txbuf;
    } cansf_state_t;

endpackage

/* File: core/cansf_lowest_one.sv */
// Lowest-set-bit picker for the transmit buffer select value.
`timescale 1ns/1ns
`default_nettype none

module cansf_lowest_one
    import cansf_pkg::*;
(
    // Raw select bits
    input wire logic [2:0] bits,
    // Picked buffer
    output logic [2:0] onehot,
    output logic [1:0] index,
    output logic any
);

    always_comb
    begin
        onehot = 3'h0;
        index = 2'h0;
        any = 1'b0;
        // Scan from the top so the lowest set bit is the last one kept.
        for (int i = NUM_TXBUF - 1; i >= 0; i--)
        begin
            if (bits[i])
            begin
                onehot = 3'h0;
                onehot[i] = 1'b1;
                index = 2'(i);
                any = 1'b1;
            end
        end
    end

endmodule // cansf_lowest_one

`default_nettype wire

/* File: core/cansf_ctl.sv */
// Abort acknowledge, transmit buffer select and acceptance control block.
//
// Overview of operation
// - Abort acknowledge flags held at reset value in initialisation mode.
// - Abort acknowledge flags readable anytime; writes to them are ignored.
// - One abort flag per buffer, set when its message was cancelled.
// - Clearing a buffer empty flag also clears that buffer's abort flag.
// - Buffer select held at reset value during initialisation mode.
// - Buffer select writable only when request and acknowledge both clear.
// - Buffer select reads back only its lowest set bit.
// - Lowest set select bit maps that buffer into the transmit window.
// - Window access blocked while the selected buffer is queued.
// - With no buffer selected every window access is refused.
// - Filter control writable only in initialisation mode; hit read-only.
// - Mode field: two 32-bit, four 16-bit, eight 8-bit filters, or closed.
// - Closed filter accepts nothing; foreground buffer never reloaded.
// - Hit field reports binary index 0 to 7 of matching filter.
// - Hit field updated whenever a message enters the foreground buffer.
// - Empty flag set on successful send or granted abort; software clears.
// - Abort granted only before transmission starts or after failed attempt.
`timescale 1ns/1ns
`default_nettype none

module cansf_ctl
    import cansf_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Avalon-MM slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic [1:0] avs_response,
    output logic avs_waitrequest,
    // Transmit engine
    input wire logic [2:0] tx_sent,
    input wire logic [2:0] tx_failed,
    input wire logic [2:0] tx_active,
    output logic [2:0] tx_queued,
    output logic [2:0] tx_abort_pending,
    // Receive path
    input wire logic rx_to_foreground,
    input wire logic [2:0] rx_hit_index,
    output logic [1:0] filter_mode,
    output logic filter_closed,
    // Mode status
    output logic init_mode
);

    cansf_state_t st_r;
    cansf_state_t st_nxt;

    logic [2:0] sel_onehot;
    logic [1:0] sel_index;
    logic sel_any;
    logic [2:0] abort_grant;

    logic take;
    logic take_rd;
    logic fire_wr;
    logic in_init;
    logic out_init;
    logic lane0;
    logic win_open;
    logic [2:0] hit_shown;
    logic [DATA_W-1:0] win_word;

    // One write strobe per writable register, already qualified by any mode or window gate it has.
    logic wr_empty;
    logic wr_abort;
    logic wr_init;
    logic wr_select;
    logic wr_mode;
    logic wr_window;

    cansf_lowest_one u_pick (
        .bits(st_r.select),
        .onehot(sel_onehot),
        .index(sel_index),
        .any(sel_any)
    );

    // An abort can only win while the frame is not on the wire, or once
    // the engine has given up on the attempt in this very cycle.
    genvar g;
    generate
        for (g = 0; g < NUM_TXBUF; g++)
        begin : g_grant
            assign abort_grant[g] = st_r.abort_req[g] && !st_r.empty[g]
                && (!tx_active[g] || tx_failed[g]) && !tx_sent[g];
        end
    endgenerate

    always_comb
    begin
        st_nxt = st_r;
        take = (avs_read || avs_write) && st_r.wait_req;
        take_rd = take && avs_read;
        fire_wr = avs_write && !st_r.wait_req;
        in_init = st_r.init_req && st_r.init_ack;
        out_init = !st_r.init_req && !st_r.init_ack;
        lane0 = avs_byteenable[0];
        win_open = sel_any && st_r.empty[sel_index];
        hit_shown = st_r.hit;
        win_word = st_r.txbuf[sel_index];

        // Each register write is decoded once here, with any mode or window gate,
        // so the update code below only says what the write does.
        wr_empty = fire_wr && lane0 && out_init
            && avs_address == OFS_EMPTY_FLAGS;
        wr_abort = fire_wr && lane0 && out_init
            && avs_address == OFS_ABORT_REQ;
        wr_init = fire_wr && lane0 && avs_address == OFS_INIT_CTL;
        wr_select = fire_wr && lane0 && out_init
            && avs_address == OFS_TX_SELECT;
        wr_mode = fire_wr && lane0 && in_init
            && avs_address == OFS_FILTER_CTL;
        wr_window = fire_wr && win_open
            && avs_address == OFS_TX_WINDOW;

        // Every request waits exactly one cycle, then is answered.
        st_nxt.wait_req = !take;

        // The acknowledge trails the request by one clock.
        st_nxt.init_ack = st_r.init_req;

        // Software clears come first so hardware sets win the same cycle.
        if (wr_empty)
        begin
            for (int i = 0; i < NUM_TXBUF; i++)
            begin
                if (avs_writedata[i])
                begin
                    st_nxt.empty[i] = 1'b0;
                    st_nxt.abort_done[i] = 1'b0;
                end
            end
        end

        if (wr_abort)
        begin
            for (int i = 0; i < NUM_TXBUF; i++)
            begin
                if (avs_writedata[i] && !st_r.empty[i])
                begin
                    st_nxt.abort_req[i] = 1'b1;
                end
            end
        end

        for (int i = 0; i < NUM_TXBUF; i++)
        begin
            if (tx_sent[i])
            begin
                st_nxt.empty[i] = 1'b1;
                st_nxt.abort_req[i] = 1'b0;
                st_nxt.abort_done[i] = 1'b0;
            end
            if (abort_grant[i])
            begin
                st_nxt.empty[i] = 1'b1;
                st_nxt.abort_req[i] = 1'b0;
                st_nxt.abort_done[i] = 1'b1;
            end
        end

        if (wr_init)
        begin
            st_nxt.init_req = avs_writedata[INIT_REQ_BIT];
        end

        // A zero write leaves no bit set, so nothing is selected.
        if (wr_select)
        begin
            st_nxt.select = avs_writedata[2:0];
        end

        // Mode and hit share one byte; only the mode field is writable.
        if (wr_mode)
        begin
            st_nxt.mode =
                cansf_mode_t'(avs_writedata[MODE_MSB:MODE_LSB]);
        end

        // Window writes honour byte lanes and land only in an open buffer.
        if (wr_window)
        begin
            for (int b = 0; b < 4; b++)
            begin
                if (avs_byteenable[b])
                begin
                    st_nxt.txbuf[sel_index][b*8 +: 8] =
                        avs_writedata[b*8 +: 8];
                end
            end
        end

        // The hit index follows the foreground buffer; a closed filter
        // never lets a message through, so it never moves.
        if (rx_to_foreground && st_r.mode != FM_CLOSED)
        begin
            st_nxt.hit = rx_hit_index;
        end

        // Initialisation mode holds these at their reset values.
        if (in_init)
        begin
            st_nxt.abort_done = FLAGS_RST;
            st_nxt.select = FLAGS_RST;
        end

        st_nxt.init_mode = st_nxt.init_req && st_nxt.init_ack;
        st_nxt.closed = (st_nxt.mode == FM_CLOSED);

        // The queued pins get their own register so no inverter sits
        // between a flip-flop and the engine.
        st_nxt.queued = ~st_nxt.empty;

        // Read data and response are captured at the accepting edge and
        // stand for the answer cycle.
        if (take)
        begin
            st_nxt.rdata = WORD_ZERO;
            st_nxt.resp = RESP_OKAY;
            case (avs_address)
                OFS_ABORT_ACK:
                begin
                    st_nxt.rdata[2:0] = st_r.abort_done;
                end
                OFS_TX_SELECT:
                begin
                    st_nxt.rdata[2:0] = sel_onehot;
                end
                OFS_FILTER_CTL:
                begin
                    st_nxt.rdata[MODE_MSB:MODE_LSB] = st_r.mode;
                    st_nxt.rdata[HIT_MSB:HIT_LSB] = hit_shown;
                end
                OFS_EMPTY_FLAGS:
                begin
                    st_nxt.rdata[2:0] = st_r.empty;
                end
                OFS_ABORT_REQ:
                begin
                    st_nxt.rdata[2:0] = st_r.abort_req;
                end
                OFS_INIT_CTL:
                begin
                    st_nxt.rdata[INIT_REQ_BIT] = st_r.init_req;
                    st_nxt.rdata[INIT_ACK_BIT] = st_r.init_ack;
                end
                OFS_TX_WINDOW:
                begin
                    if (win_open)
                    begin
                        if (take_rd)
                        begin
                            st_nxt.rdata = win_word;
                        end
                    end
                    else
                    begin
                        st_nxt.resp = RESP_SLVERR;
                    end
                end
                default:
                begin
                    st_nxt.resp = RESP_DECERR;
                end
            endcase
            if (!take_rd)
            begin
                st_nxt.rdata = WORD_ZERO;
            end
        end
    end

    // All flags come up idle; every buffer starts empty and unselected.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st_r.wait_req <= 1'b1;
            st_r.rdata <= WORD_ZERO;
            st_r.resp <= RESP_OKAY;
            st_r.init_req <= 1'b0;
            st_r.init_ack <= 1'b0;
            st_r.init_mode <= 1'b0;
            st_r.empty <= EMPTY_RST;
            st_r.queued <= ~EMPTY_RST;
            st_r.abort_done <= FLAGS_RST;
            st_r.abort_req <= FLAGS_RST;
            st_r.select <= FLAGS_RST;
            st_r.mode <= cansf_mode_t'(MODE_RST);
            st_r.closed <= 1'b0;
            st_r.hit <= FLAGS_RST;
            st_r.txbuf <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign avs_readdata = st_r.rdata;
    assign avs_response = st_r.resp;
    assign avs_waitrequest = st_r.wait_req;
    // Pins are register fields only, so no decode glitch reaches them.
    assign tx_queued = st_r.queued;
    assign tx_abort_pending = st_r.abort_req;
    assign filter_mode = st_r.mode;
    assign filter_closed = st_r.closed;
    assign init_mode = st_r.init_mode;

endmodule // cansf_ctl

`default_nettype wire

/* File: bench/cansf_ctl_properties.sv */
// Port checks of the abort, select and filter control block.
`timescale 1ns/1ns
`default_nettype none
module cansf_ctl_properties
    import cansf_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Bus handshake
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    // Engine and filter status
    input wire logic [2:0] tx_sent,
    input wire logic [2:0] tx_failed,
    input wire logic [2:0] tx_active,
    input wire logic [2:0] tx_queued,
    input wire logic [2:0] tx_abort_pending,
    input wire logic [1:0] filter_mode,
    input wire logic filter_closed,
    input wire logic init_mode
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    property p_answer;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_answer: assert property (p_answer) else $error("no answer");
    property p_single;
        !avs_waitrequest |=> avs_waitrequest;
    endproperty
    a_single: assert property (p_single) else $error("long answer");
    property p_closed;
        filter_closed == (filter_mode == FM_CLOSED);
    endproperty
    a_closed: assert property (p_closed) else $error("closed");
    property p_mode;
        $changed(filter_mode) |-> $past(init_mode);
    endproperty
    a_mode: assert property (p_mode) else $error("mode write");
    property p_pend;
        (tx_abort_pending & ~tx_queued) == 3'h0;
    endproperty
    a_pend: assert property (p_pend) else $error("request");
    property p_empty;
        (~tx_queued & $past(tx_queued) & ~$past(tx_sent)
            & ~$past(tx_abort_pending)) == 3'h0;
    endproperty
    a_empty: assert property (p_empty) else $error("empty");
    property p_grant;
        (~tx_queued & $past(tx_queued) & $past(tx_active)
            & ~$past(tx_failed) & ~$past(tx_sent)) == 3'h0;
    endproperty
    a_grant: assert property (p_grant) else $error("grant");
    property p_queue;
        (tx_queued & ~$past(tx_queued)) != 3'h0 |-> !$past(init_mode);
    endproperty
    a_queue: assert property (p_queue) else $error("queue");
endmodule // cansf_ctl_properties
bind cansf_ctl cansf_ctl_properties u_props (.clk, .reset_n, .avs_read,
    .avs_write, .avs_waitrequest, .tx_sent, .tx_failed, .tx_active,
    .tx_queued, .tx_abort_pending, .filter_mode, .filter_closed, .init_mode);
`default_nettype wire

/* File: bench/cansf_engine_model.sv */
// Behavioural transmit engine and receive feeder.
`timescale 1ns/1ns
`default_nettype none
module cansf_engine_model (
    // Clock
    input wire logic clk,
    // Bench commands
    input wire logic [2:0] go,
    input wire logic fail,
    input wire logic rx_go,
    input wire logic [2:0] rx_idx,
    // Control block side
    input wire logic [2:0] tx_queued,
    output logic [2:0] tx_sent = 3'h0,
    output logic [2:0] tx_failed = 3'h0,
    output logic [2:0] tx_active = 3'h0,
    output logic rx_to_foreground = 1'b0,
    output logic [2:0] rx_hit_index = 3'h0
);
    logic [2:0] cnt = 3'h0;
    logic [2:0] pick;
    assign pick = go & tx_queued;
    // Starts wait for a full count so a just aborted buffer is not resent.
    always @(posedge clk)
    begin
        tx_sent <= 3'h0;
        tx_failed <= 3'h0;
        rx_to_foreground <= rx_go;
        rx_hit_index <= rx_go ? rx_idx : ~rx_hit_index;
        cnt <= cnt + 3'h1;
        if (tx_active != 3'h0 && cnt == 3'h7)
        begin
            tx_sent <= fail ? 3'h0 : tx_active;
            tx_failed <= fail ? tx_active : 3'h0;
            tx_active <= 3'h0;
        end
        else if (tx_active == 3'h0 && pick != 3'h0 && cnt == 3'h7)
            tx_active <= pick & (~pick + 3'h1);
    end
endmodule // cansf_engine_model
`default_nettype wire

/* File: bench/tb.sv */
// Self-checking bench for the abort, select and filter control block.
`timescale 1ns/1ns
`default_nettype none
module tb
    import cansf_pkg::*;
    ;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = WORD_ZERO;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata, q;
    logic [1:0] avs_response, r, filter_mode;
    logic avs_waitrequest, rx_to_foreground, filter_closed, init_mode;
    logic [2:0] tx_sent, tx_failed, tx_active, tx_queued, tx_abort_pending;
    logic [2:0] rx_hit_index, go = 3'h0, rx_idx = 3'h0;
    logic fail = 1'b0;
    logic rx_go = 1'b0;
    int mismatches = 0;
    int n_checks = 0;
    cansf_ctl u_dut (.clk, .reset_n, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_response,
        .avs_waitrequest, .tx_sent, .tx_failed, .tx_active, .tx_queued,
        .tx_abort_pending, .rx_to_foreground, .rx_hit_index, .filter_mode,
        .filter_closed, .init_mode);
    cansf_engine_model u_eng (.clk, .go, .fail, .rx_go, .rx_idx, .tx_queued,
        .tx_sent, .tx_failed, .tx_active, .rx_to_foreground, .rx_hit_index);
    always #5 clk = ~clk;
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] s);
        n_checks++;
        if (s !== e)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic bus(input logic w, input logic [4:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 20);
        q = avs_readdata;
        r = avs_response;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n >= 20)
        begin
            mismatches++;
            finish_test();
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] e,
        input logic [1:0] re = RESP_OKAY);
        bus(1'b0, a, WORD_ZERO);
        chk($sformatf("data at %h", a), {24'h00_0000, e}, q);
        chk($sformatf("response at %h", a), {30'h0, re}, {30'h0, r});
    endtask
    // Waits for a buffer to go active (v) or to be flagged empty.
    task automatic wt(input logic [2:0] m, input logic v);
        int n;
        n = 0;
        while ((((v ? tx_active : ~tx_queued) & m) !== m) && n < 60)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 60)
        begin
            mismatches++;
            finish_test();
        end
    endtask
    task automatic rx(input logic [2:0] i);
        @(posedge clk);
        rx_go <= 1'b1;
        rx_idx <= i;
        @(posedge clk);
        rx_go <= 1'b0;
    endtask
    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        finish_test();
    end
    initial
    begin
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        rd(OFS_ABORT_ACK, 8'h00);
        rd(OFS_TX_SELECT, 8'h00);
        rd(OFS_FILTER_CTL, 8'h00);
        rd(OFS_EMPTY_FLAGS, 8'h07);
        rd(5'h1c, 8'h00, RESP_DECERR);
        wr(OFS_ABORT_ACK, 32'h0000_00ff);
        rd(OFS_ABORT_ACK, 8'h00);
        for (int i = 0; i < 8; i++)
        begin
            wr(OFS_TX_SELECT, 32'(i));
            rd(OFS_TX_SELECT, 8'(i & -i));
        end
        for (int i = 1; i < 4; i++)
        begin
            wr(OFS_TX_SELECT, 32'(i));
            wr(OFS_TX_WINDOW, 32'h1234_5670 + 32'(i));
        end
        for (int i = 2; i < 4; i++)
        begin
            wr(OFS_TX_SELECT, 32'(i));
            bus(1'b0, OFS_TX_WINDOW, WORD_ZERO);
            chk("window", 32'h1234_5670 + 32'(i), q);
        end
        avs_byteenable <= 4'h2;
        wr(OFS_TX_WINDOW, 32'hffff_a5ff);
        avs_byteenable <= 4'hf;
        bus(1'b0, OFS_TX_WINDOW, WORD_ZERO);
        chk("lanes", 32'h1234_a573, q);
        wr(OFS_TX_SELECT, WORD_ZERO);
        rd(OFS_TX_WINDOW, 8'h00, RESP_SLVERR);
        $display("test select done");
        wr(OFS_EMPTY_FLAGS, 32'h0000_0001);
        wr(OFS_TX_SELECT, 32'h0000_0001);
        rd(OFS_TX_WINDOW, 8'h00, RESP_SLVERR);
        wr(OFS_ABORT_REQ, 32'h0000_0001);
        wt(3'h1, 1'b0);
        rd(OFS_ABORT_ACK, 8'h01);
        wr(OFS_EMPTY_FLAGS, 32'h0000_0001);
        rd(OFS_ABORT_ACK, 8'h00);
        go <= 3'h1;
        wt(3'h1, 1'b0);
        rd(OFS_ABORT_ACK, 8'h00);
        go <= 3'h2;
        wr(OFS_EMPTY_FLAGS, 32'h0000_0002);
        wt(3'h2, 1'b1);
        wr(OFS_ABORT_REQ, 32'h0000_0002);
        rd(OFS_ABORT_REQ, 8'h02);
        chk("pending", 32'h0000_0002, {29'h0, tx_abort_pending});
        wt(3'h2, 1'b0);
        rd(OFS_ABORT_ACK, 8'h00);
        fail <= 1'b1;
        wr(OFS_EMPTY_FLAGS, 32'h0000_0002);
        wr(OFS_ABORT_REQ, 32'h0000_0002);
        wt(3'h2, 1'b0);
        rd(OFS_ABORT_ACK, 8'h02);
        go <= 3'h0;
        wr(OFS_EMPTY_FLAGS, 32'h0000_0001);
        bus(1'b0, OFS_EMPTY_FLAGS, WORD_ZERO);
        chk("free", 32'h0000_0006, q);
        wr(OFS_TX_SELECT, q);
        rd(OFS_TX_SELECT, 8'h02);
        $display("test abort done");
        wr(OFS_INIT_CTL, 32'h0000_0001);
        rd(OFS_INIT_CTL, 8'h03);
        chk("init mode", 32'h0000_0001, {31'h0, init_mode});
        rd(OFS_ABORT_ACK, 8'h00);
        wr(OFS_TX_SELECT, 32'h0000_0002);
        rd(OFS_TX_SELECT, 8'h00);
        for (int m = 0; m < 4; m++)
        begin
            wr(OFS_FILTER_CTL, 32'(m * 16 + 7));
            rd(OFS_FILTER_CTL, 8'(m * 16));
            chk("closed", {31'h0, m == 3}, {31'h0, filter_closed});
            chk("mode", 32'(m), {30'h0, filter_mode});
        end
        wr(OFS_INIT_CTL, WORD_ZERO);
        wr(OFS_FILTER_CTL, 32'h0000_0010);
        rd(OFS_FILTER_CTL, 8'h30);
        wr(OFS_TX_SELECT, 32'h0000_0004);
        rd(OFS_TX_SELECT, 8'h04);
        rx(3'h5);
        rd(OFS_FILTER_CTL, 8'h30);
        wr(OFS_INIT_CTL, 32'h0000_0001);
        wr(OFS_FILTER_CTL, 32'h0000_0010);
        wr(OFS_INIT_CTL, WORD_ZERO);
        for (int i = 7; i >= 0; i--)
        begin
            rx(3'(i));
            rd(OFS_FILTER_CTL, 8'(16 + i));
        end
        $display("test init and filter done");
        finish_test();
    end
endmodule // tb
`default_nettype wire
